//--- fcds_dev.sv
// Functional notes
// RULE_01 - Four channels, one read then one write
// RULE_02 - Narrow data rides the upper byte lanes
// RULE_03 - Pointer is 16-bit segment plus 14-bit offset
// RULE_04 - Host splits transfers at segment boundaries
// RULE_05 - Host preloads offsets into sixteen-word RAM
// RULE_06 - Address bits one and zero held low
// RULE_07 - Offsets step per pair unless inhibited
// RULE_08 - Latch holds read word for the write
// RULE_09 - Burst, wait, block are 14-bit down-counters
// RULE_10 - Burst end releases bus for wait count
// RULE_11 - Block count decrements; zero ends operation
// RULE_12 - Only a start-bit write begins work
// RULE_13 - Load pointers and counters, then request bus
// RULE_14 - Transfers begin only after bus grant
// RULE_15 - Lost grant in final write: release, re-request
// RULE_16 - Block zero in final write: go idle
// RULE_17 - Burst zero: wait, then reload burst
// RULE_18 - Counts nonzero, grant held: next pair
// RULE_19 - Sequencer uses both clock edges
// RULE_20 - Reset to initialise, fixed load order
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "fcds_defs.svh"

module fcds_dev (
	input  wire logic clk_sys,
	input  wire logic rst,
	output logic      busy,
	fcds_link.dev     lnk
);
	fcds_pkg::fcds_state_t state;
	fcds_pkg::fcds_state_t next_state;
	fcds_pkg::fcds_ram_t   ram     [`FCDS_RAM_N];
	fcds_pkg::fcds_seg_t   segSrc  [`FCDS_CH_N];
	fcds_pkg::fcds_seg_t   segDst  [`FCDS_CH_N];
	fcds_pkg::fcds_cnt_t   waitLen [`FCDS_CH_N];
	fcds_pkg::fcds_cmd_t   cmd;
	fcds_pkg::fcds_cnt_t   srcOff;
	fcds_pkg::fcds_cnt_t   dstOff;
	fcds_pkg::fcds_cnt_t   blk;
	fcds_pkg::fcds_cnt_t   burst;
	fcds_pkg::fcds_cnt_t   waitCnt;
	fcds_pkg::fcds_word_t  latch;
	logic                  ackSeen;
	logic                  done;
	logic [`FCDS_CH_W-1:0] ch;
	logic [`FCDS_PW_W-1:0] pw;
	fcds_pkg::fcds_ram_t   ramWord;
	fcds_pkg::fcds_cnt_t   ramCnt;
	fcds_pkg::fcds_cnt_t   blkNext;
	fcds_pkg::fcds_cnt_t   srcStep;
	fcds_pkg::fcds_cnt_t   dstStep;
	logic                  cmdWr;
	logic                  start;
	logic                  blkZero;
	logic                  burstZero;
	logic                  waitZero;
	logic                  inBus;
	logic                  inWrite;

	assign ch = cmd[`FCDS_CMD_CH];
	assign pw = (state == fcds_pkg::ST_LD_SRC) ? `FCDS_PW_SRC :
		(state == fcds_pkg::ST_LD_DST) ? `FCDS_PW_DST :
		(state == fcds_pkg::ST_LD_BLK) ? `FCDS_PW_BLK : `FCDS_PW_BST;
	assign ramWord = ram[{ch, pw}];
	assign ramCnt = ramWord[`FCDS_CNT_W-1:0];
	assign cmdWr = lnk.cpuWe && (lnk.cpuTgt == `FCDS_TGT_CMD);
	assign start = cmdWr && lnk.cpuData[`FCDS_CMD_GO]
		&& (state == fcds_pkg::ST_IDLE);                    // [RULE_12]
	assign blkNext = blk - `FCDS_CNT_ONE;
	assign blkZero = (blkNext == `FCDS_CNT_ZERO);
	// A burst length of zero behaves as one pair
	assign burstZero = (burst <= `FCDS_CNT_ONE);
	assign waitZero = (waitCnt == `FCDS_CNT_ZERO);
	assign srcStep = cmd[`FCDS_CMD_SHOLD] ? `FCDS_CNT_ZERO : `FCDS_CNT_ONE;
	assign dstStep = cmd[`FCDS_CMD_DHOLD] ? `FCDS_CNT_ZERO : `FCDS_CNT_ONE;
	assign inBus = state inside {fcds_pkg::ST_READ_1, fcds_pkg::ST_READ_2,
		fcds_pkg::ST_WRITE_1, fcds_pkg::ST_WRITE_2, fcds_pkg::ST_FINAL};
	assign inWrite = state inside {fcds_pkg::ST_WRITE_1,
		fcds_pkg::ST_WRITE_2, fcds_pkg::ST_FINAL};
	assign busy = !(state inside {fcds_pkg::ST_INIT, fcds_pkg::ST_IDLE});

	// Host-side parameter, segment and wait-length stores
	always_ff @(posedge clk_sys) begin
		if (lnk.cpuWe) begin
			unique case (lnk.cpuTgt)
			`FCDS_TGT_RAM: ram[lnk.cpuAddr] <= lnk.cpuData;         // [RULE_05]
			`FCDS_TGT_CMD: ;
			`FCDS_TGT_SEG: begin
				if (lnk.cpuAddr[`FCDS_SEG_DST])
					segDst[lnk.cpuAddr[`FCDS_SEG_CH]] <= lnk.cpuData;
				else
					segSrc[lnk.cpuAddr[`FCDS_SEG_CH]] <= lnk.cpuData;
			end
			`FCDS_TGT_WAIT: waitLen[lnk.cpuAddr[`FCDS_SEG_CH]] <=
				lnk.cpuData[`FCDS_CNT_W-1:0];
			endcase
		end
	end

	// Channel and mode stay fixed while an operation runs
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			cmd <= `FCDS_CMD_RST;
		else if (cmdWr && (state == fcds_pkg::ST_IDLE))
			cmd <= lnk.cpuData[`FCDS_CMD_W-1:0];
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			state <= fcds_pkg::ST_INIT;                             // [RULE_20]
		else
			state <= next_state;
	end

	always_comb begin
		next_state = state;
		unique case (state)
		fcds_pkg::ST_INIT: next_state = fcds_pkg::ST_IDLE;          // [RULE_20]
		fcds_pkg::ST_IDLE:
			if (start)
				next_state = fcds_pkg::ST_LD_SRC;                   // [RULE_12]
		fcds_pkg::ST_LD_SRC: next_state = fcds_pkg::ST_LD_DST;      // [RULE_20]
		fcds_pkg::ST_LD_DST: next_state = fcds_pkg::ST_LD_BLK;      // [RULE_13]
		fcds_pkg::ST_LD_BLK:
			if (ramCnt == `FCDS_CNT_ZERO)
				next_state = fcds_pkg::ST_IDLE;                     // [RULE_11]
			else
				next_state = fcds_pkg::ST_LD_BURST;
		fcds_pkg::ST_LD_BURST: next_state = fcds_pkg::ST_BUS_REQ;   // [RULE_13]
		fcds_pkg::ST_BUS_REQ:
			if (lnk.busGrant)
				next_state = fcds_pkg::ST_READ_1;                   // [RULE_14]
		fcds_pkg::ST_READ_1:
			if (ackSeen)
				next_state = fcds_pkg::ST_READ_2;                   // [RULE_19]
		fcds_pkg::ST_READ_2: next_state = fcds_pkg::ST_WRITE_1;     // [RULE_01]
		fcds_pkg::ST_WRITE_1:
			if (ackSeen)
				next_state = fcds_pkg::ST_WRITE_2;                  // [RULE_19]
		fcds_pkg::ST_WRITE_2: next_state = fcds_pkg::ST_FINAL;
		fcds_pkg::ST_FINAL: begin
			if (blkZero)
				next_state = fcds_pkg::ST_IDLE;                     // [RULE_16]
			else if (burstZero)
				next_state = fcds_pkg::ST_WAIT;                     // [RULE_17]
			else if (!lnk.busGrant)
				next_state = fcds_pkg::ST_BUS_REQ;                  // [RULE_15]
			else
				next_state = fcds_pkg::ST_READ_1;                   // [RULE_18]
		end
		fcds_pkg::ST_WAIT:
			if (waitZero)
				next_state = fcds_pkg::ST_LD_BURST;                 // [RULE_17]
		default: next_state = fcds_pkg::ST_INIT;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			srcOff <= `FCDS_CNT_ZERO;
			dstOff <= `FCDS_CNT_ZERO;
			blk <= `FCDS_CNT_ZERO;
			burst <= `FCDS_CNT_ZERO;
			waitCnt <= `FCDS_CNT_ZERO;
			done <= 1'b0;
		end else begin
			done <= busy && (next_state == fcds_pkg::ST_IDLE);
			unique case (state)
			fcds_pkg::ST_LD_SRC: srcOff <= ramCnt;                  // [RULE_13]
			fcds_pkg::ST_LD_DST: dstOff <= ramCnt;                  // [RULE_13]
			fcds_pkg::ST_LD_BLK: blk <= ramCnt;                     // [RULE_11]
			fcds_pkg::ST_LD_BURST: burst <= ramCnt;                 // [RULE_10]
			fcds_pkg::ST_FINAL: begin
				// Offsets wrap inside the segment
				srcOff <= srcOff + srcStep;                         // [RULE_07]
				dstOff <= dstOff + dstStep;                         // [RULE_07]
				blk <= blkNext;                                     // [RULE_11]
				burst <= burst - `FCDS_CNT_ONE;                     // [RULE_09]
				waitCnt <= waitLen[ch];                             // [RULE_10]
			end
			fcds_pkg::ST_WAIT:
				if (!waitZero)
					waitCnt <= waitCnt - `FCDS_CNT_ONE;             // [RULE_09]
			default: ;
			endcase
		end
	end

	// Falling-edge capture gives the next rising edge a half-cycle head start
	always_ff @(negedge clk_sys or posedge rst) begin
		if (rst) begin
			ackSeen <= 1'b0;
			latch <= `FCDS_WORD_ZERO;
		end else begin
			ackSeen <= lnk.memAck;                                  // [RULE_19]
			if ((state == fcds_pkg::ST_READ_1) && lnk.memAck)
				latch <= lnk.memRdata;                              // [RULE_08]
		end
	end

	// Bus is dropped while waiting out the burst gap
	assign lnk.busReq = inBus || (state == fcds_pkg::ST_BUS_REQ); // [RULE_10]
	assign lnk.busOe = inBus;                                       // [RULE_15]
	assign lnk.memRead = (state == fcds_pkg::ST_READ_1);            // [RULE_01]
	assign lnk.memWrite = (state == fcds_pkg::ST_WRITE_1);          // [RULE_01]
	assign lnk.memAddr = !inBus ? `FCDS_WORD_ZERO :
		inWrite ? {segDst[ch], dstOff, `FCDS_LW_PAD} :              // [RULE_06]
		{segSrc[ch], srcOff, `FCDS_LW_PAD};                         // [RULE_03]
	assign lnk.memWdata = latch;                                    // [RULE_08]
	assign lnk.memSize = cmd[`FCDS_CMD_SZ];                         // [RULE_02]
	assign lnk.dmaBusy = busy;
	assign lnk.dmaDone = done;
endmodule
`default_nettype wire

//--- fcds_defs.svh
`ifndef FCDS_DEFS_SVH
`define FCDS_DEFS_SVH
`define FCDS_DW       32
`define FCDS_AW       12
`define FCDS_CNT_W    14
`define FCDS_SEG_W    16
`define FCDS_RAM_W    16
`define FCDS_RAM_N    16
`define FCDS_RAMA_W   4
`define FCDS_CH_N     4
`define FCDS_CH_W     2
`define FCDS_PW_W     2
`define FCDS_TGT_W    2
`define FCDS_SZ_W     2
`define FCDS_ST_W     4
`define FCDS_CMD_W    8
`define FCDS_MEM_N    64
`define FCDS_CNT_ZERO 14'h0000
`define FCDS_CNT_ONE  14'h0001
`define FCDS_WORD_ZERO 32'h00000000
`define FCDS_LW_PAD   2'h0
`define FCDS_CMD_RST  8'h00
`define FCDS_CMD_GO   0
`define FCDS_CMD_CH   2:1
`define FCDS_CMD_SHOLD 3
`define FCDS_CMD_DHOLD 4
`define FCDS_CMD_SZ   6:5
`define FCDS_SZ_BYTE  2'h1
`define FCDS_SZ_HALF  2'h2
`define FCDS_MASK_B   32'hFF000000
`define FCDS_MASK_H   32'hFFFF0000
`define FCDS_MASK_W   32'hFFFFFFFF
`define FCDS_PW_SRC   2'h0
`define FCDS_PW_DST   2'h1
`define FCDS_PW_BLK   2'h2
`define FCDS_PW_BST   2'h3
`define FCDS_TGT_RAM  2'h0
`define FCDS_TGT_CMD  2'h1
`define FCDS_TGT_SEG  2'h2
`define FCDS_TGT_WAIT 2'h3
`define FCDS_SEG_DST  2
`define FCDS_SEG_CH   1:0
`define FCDS_A_CMD    12'h000
`define FCDS_A_STAT   12'h004
`define FCDS_A_CTRL   12'h008
`define FCDS_A_RAMF   11:6
`define FCDS_A_RAM    6'h01
`define FCDS_A_IDX    5:2
`define FCDS_A_SEGF   11:5
`define FCDS_A_SEG    7'h04
`define FCDS_A_SIDX   4:2
`define FCDS_A_WAITF  11:4
`define FCDS_A_WAIT   8'h0A
`define FCDS_A_WIDX   3:2
`define FCDS_A_MEMF   11:8
`define FCDS_A_MEM    4'h1
`define FCDS_A_MIDX   7:2
`define FCDS_CTRL_GRANT 0
`define FCDS_RESP_OK  2'h0
`define FCDS_RESP_ERR 2'h2
`endif

//--- fcds_pkg.sv
`default_nettype none
`include "fcds_defs.svh"
package fcds_pkg;
	typedef logic [`FCDS_CNT_W-1:0] fcds_cnt_t;
	typedef logic [`FCDS_SEG_W-1:0] fcds_seg_t;
	typedef logic [`FCDS_RAM_W-1:0] fcds_ram_t;
	typedef logic [`FCDS_DW-1:0]    fcds_word_t;
	typedef logic [`FCDS_CMD_W-1:0] fcds_cmd_t;
	typedef enum logic [`FCDS_ST_W-1:0] {
		ST_INIT, ST_IDLE, ST_LD_SRC, ST_LD_DST, ST_LD_BLK, ST_LD_BURST,
		ST_BUS_REQ, ST_READ_1, ST_READ_2, ST_WRITE_1, ST_WRITE_2,
		ST_FINAL, ST_WAIT
	} fcds_state_t;
endpackage
`default_nettype wire

//--- fcds_link.sv
`timescale 1ns/10ps
`default_nettype none
`include "fcds_defs.svh"
interface fcds_link;
	logic                   cpuWe;
	logic [`FCDS_TGT_W-1:0] cpuTgt;
	logic [`FCDS_RAMA_W-1:0] cpuAddr;
	logic [`FCDS_RAM_W-1:0] cpuData;
	logic                   busReq;
	logic                   busGrant;
	logic [`FCDS_DW-1:0]    memAddr;
	logic                   memRead;
	logic                   memWrite;
	logic [`FCDS_DW-1:0]    memWdata;
	logic [`FCDS_SZ_W-1:0]  memSize;
	logic                   busOe;
	logic [`FCDS_DW-1:0]    memRdata;
	logic                   memAck;
	logic                   dmaBusy;
	logic                   dmaDone;
	modport dev (
		input  cpuWe, cpuTgt, cpuAddr, cpuData, busGrant, memRdata, memAck,
		output busReq, memAddr, memRead, memWrite, memWdata, memSize,
		output busOe, dmaBusy, dmaDone
	);
	modport host (
		output cpuWe, cpuTgt, cpuAddr, cpuData, busGrant, memRdata, memAck,
		input  busReq, memAddr, memRead, memWrite, memWdata, memSize,
		input  busOe, dmaBusy, dmaDone
	);
endinterface
`default_nettype wire

//--- fcds_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "fcds_defs.svh"

module fcds_host (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire logic [`FCDS_AW-1:0] s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [`FCDS_DW-1:0] s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [`FCDS_AW-1:0] s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [`FCDS_DW-1:0]      s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	fcds_link.host                   lnk
);
	logic                    awHeld;
	logic                    wHeld;
	logic [`FCDS_AW-1:0]     awA;
	fcds_pkg::fcds_word_t    wD;
	logic [3:0]              wS;
	fcds_pkg::fcds_word_t    mem [`FCDS_MEM_N];
	logic                    grantEn;
	logic [7:0]              doneCnt;
	logic                    doWr;
	logic                    wCmd;
	logic                    wCtrl;
	logic                    wRam;
	logic                    wSeg;
	logic                    wWait;
	logic                    wMem;
	logic                    wLink;
	logic                    wOk;
	logic                    rStat;
	logic                    rCtrl;
	logic                    rMem;
	fcds_pkg::fcds_word_t    rWord;
	fcds_pkg::fcds_word_t    merged;
	fcds_pkg::fcds_word_t    lOld;
	fcds_pkg::fcds_word_t    lane;
	logic [`FCDS_TGT_W-1:0]  nextTgt;
	logic [`FCDS_RAMA_W-1:0] nextAddr;

	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign doWr = awHeld && wHeld && !s_axi_bvalid;
	assign wCmd = (awA == `FCDS_A_CMD);
	assign wCtrl = (awA == `FCDS_A_CTRL);
	assign wRam = (awA[`FCDS_A_RAMF] == `FCDS_A_RAM);
	assign wSeg = (awA[`FCDS_A_SEGF] == `FCDS_A_SEG);
	assign wWait = (awA[`FCDS_A_WAITF] == `FCDS_A_WAIT);
	assign wMem = (awA[`FCDS_A_MEMF] == `FCDS_A_MEM);
	assign wLink = wCmd || wRam || wSeg || wWait;
	assign wOk = wLink || wCtrl || wMem;
	assign nextTgt = wCmd ? `FCDS_TGT_CMD : wRam ? `FCDS_TGT_RAM :
		wSeg ? `FCDS_TGT_SEG : `FCDS_TGT_WAIT;
	assign nextAddr = wRam ? awA[`FCDS_A_IDX] :
		wSeg ? {1'b0, awA[`FCDS_A_SIDX]} : {2'h0, awA[`FCDS_A_WIDX]};
	assign rStat = (s_axi_araddr == `FCDS_A_STAT);
	assign rCtrl = (s_axi_araddr == `FCDS_A_CTRL);
	assign rMem = (s_axi_araddr[`FCDS_A_MEMF] == `FCDS_A_MEM);
	assign rWord = rStat ? {16'h0000, doneCnt, 4'h0, lnk.dmaBusy,
		lnk.busReq, lnk.busGrant, grantEn} :
		rCtrl ? {31'h00000000, grantEn} :
		rMem ? mem[s_axi_araddr[`FCDS_A_MIDX]] : `FCDS_WORD_ZERO;
	assign lOld = mem[lnk.memAddr[`FCDS_A_MIDX]];
	// Narrow slaves answer on the upper lanes only
	assign lane = (lnk.memSize == `FCDS_SZ_BYTE) ? `FCDS_MASK_B :
		(lnk.memSize == `FCDS_SZ_HALF) ? `FCDS_MASK_H : `FCDS_MASK_W;

	always_comb begin
		merged = mem[awA[`FCDS_A_MIDX]];
		for (int i = 0; i < 4; i++)
			if (wS[i])
				merged[i*8 +: 8] = wD[i*8 +: 8];
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awA <= `FCDS_A_CMD;
			wD <= `FCDS_WORD_ZERO;
			wS <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FCDS_RESP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awA <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wD <= s_axi_wdata;
				wS <= s_axi_wstrb;
			end
			if (doWr) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wOk ? `FCDS_RESP_OK : `FCDS_RESP_ERR;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `FCDS_WORD_ZERO;
			s_axi_rresp <= `FCDS_RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rWord;
			s_axi_rresp <= (rStat || rCtrl || rMem) ?
				`FCDS_RESP_OK : `FCDS_RESP_ERR;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Command, parameter, segment and wait writes go out as one-cycle strobes
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lnk.cpuWe <= 1'b0;
			lnk.cpuTgt <= `FCDS_TGT_RAM;
			lnk.cpuAddr <= 4'h0;
			lnk.cpuData <= 16'h0000;
			grantEn <= 1'b0;
		end else begin
			lnk.cpuWe <= doWr && wLink;                             // [RULE_12]
			if (doWr && wLink) begin
				lnk.cpuTgt <= nextTgt;                              // [RULE_04]
				lnk.cpuAddr <= nextAddr;                            // [RULE_05]
				lnk.cpuData <= wD[`FCDS_RAM_W-1:0];                 // [RULE_11]
			end
			if (doWr && wCtrl)
				grantEn <= wD[`FCDS_CTRL_GRANT];
		end
	end

	// Arbiter and memory port
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lnk.busGrant <= 1'b0;
			lnk.memAck <= 1'b0;
			lnk.memRdata <= `FCDS_WORD_ZERO;
			doneCnt <= 8'h00;
		end else begin
			lnk.busGrant <= lnk.busReq && grantEn;                  // [RULE_15]
			lnk.memAck <= (lnk.memRead || lnk.memWrite) && !lnk.memAck;
			if (lnk.memRead && !lnk.memAck)
				lnk.memRdata <= lOld & lane;                        // [RULE_02]
			doneCnt <= doneCnt + 8'(lnk.dmaDone);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (doWr && wMem)
			mem[awA[`FCDS_A_MIDX]] <= merged;
		if (lnk.memWrite && !lnk.memAck)
			mem[lnk.memAddr[`FCDS_A_MIDX]] <=
				(lnk.memWdata & lane) | (lOld & ~lane);             // [RULE_02]
	end
endmodule
`default_nettype wire

//--- fcds_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "fcds_defs.svh"
module fcds_props (
	input wire logic                   clk_sys,
	input wire logic                   rst,
	input wire logic                   cpuWe,
	input wire logic [`FCDS_TGT_W-1:0] cpuTgt,
	input wire logic [`FCDS_RAM_W-1:0] cpuData,
	input wire logic                   busReq,
	input wire logic                   busGrant,
	input wire logic [`FCDS_DW-1:0]    memAddr,
	input wire logic                   memRead,
	input wire logic                   memWrite,
	input wire logic [`FCDS_DW-1:0]    memWdata,
	input wire logic [`FCDS_DW-1:0]    memRdata,
	input wire logic                   memAck,
	input wire logic                   busOe,
	input wire logic                   dmaBusy,
	input wire logic                   dmaDone
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic                rdPrev;
	logic                rdSeen;
	logic                holdSrc;
	logic [`FCDS_DW-1:0] lastAddr;
	logic [`FCDS_DW-1:0] lastRd;
	wire goStrobe = cpuWe && cpuTgt == `FCDS_TGT_CMD
		&& cpuData[`FCDS_CMD_GO] && !dmaBusy;
	wire rdRise = memRead && !rdPrev;
	// Tracks read addresses and the word fetched per pair
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdPrev <= 1'b0;
			rdSeen <= 1'b0;
			holdSrc <= 1'b0;
			lastAddr <= `FCDS_WORD_ZERO;
			lastRd <= `FCDS_WORD_ZERO;
		end else begin
			rdPrev <= memRead;
			if (goStrobe) begin
				rdSeen <= 1'b0;
				holdSrc <= cpuData[`FCDS_CMD_SHOLD];
			end else if (rdRise) begin
				rdSeen <= 1'b1;
				lastAddr <= memAddr;
			end
			if (memRead && memAck)
				lastRd <= memRdata;
		end
	end
	a_go_starts: assert property (goStrobe |=> dmaBusy)
		else $error("busy did not follow start");
	a_load_first: assert property (
		goStrobe |=> (!busReq)[*4])
		else $error("bus request before loading done");
	a_req_runs: assert property (busReq |-> dmaBusy)
		else $error("bus request while idle");
	a_own_granted: assert property (
		$rose(busOe) |-> $past(busGrant))
		else $error("bus taken without grant");
	a_lw_align: assert property (
		(memRead || memWrite) |-> memAddr[1:0] == `FCDS_LW_PAD)
		else $error("low address bits not zero");
	a_latch_drive: assert property (memWrite |-> memWdata == lastRd)
		else $error("write data differs from read word");
	a_rd_wr_apart: assert property (memWrite |-> !memRead)
		else $error("read and write strobes together");
	a_off_step: assert property (
		rdRise && rdSeen |-> memAddr == (holdSrc ? lastAddr :
		lastAddr + 32'h00000004))
		else $error("source offset step wrong");
	a_done_idle: assert property (dmaDone |-> !dmaBusy)
		else $error("done pulse while busy");
	a_bus_release: assert property (!busOe |-> memAddr == `FCDS_WORD_ZERO)
		else $error("address driven while bus released");
endmodule
`default_nettype wire

//--- test_four_channel_dma_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "fcds_defs.svh"
module test_four_channel_dma_sequencer;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, devBusy, rdPrev;
	logic [1:0]  bresp, rresp, rs, bs;
	logic [31:0] rdata, rd;
	logic [31:0] em [64];
	int          err_total, n_compared, cyc, pairs, gap, minGap, i;
	fcds_link lnk();
	fcds_dev fcds_dev_i (.clk_sys(clk_sys), .rst(rst), .busy(devBusy), .lnk(lnk));
	fcds_host fcds_host_i (.clk_sys(clk_sys), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .lnk(lnk));
	fcds_props fcds_props_i (.clk_sys(clk_sys), .rst(rst), .cpuWe(lnk.cpuWe),
		.cpuTgt(lnk.cpuTgt), .cpuData(lnk.cpuData), .busReq(lnk.busReq),
		.busGrant(lnk.busGrant), .memAddr(lnk.memAddr), .memRead(lnk.memRead),
		.memWrite(lnk.memWrite), .memWdata(lnk.memWdata),
		.memRdata(lnk.memRdata), .memAck(lnk.memAck), .busOe(lnk.busOe),
		.dmaBusy(lnk.dmaBusy), .dmaDone(lnk.dmaDone));
	always #20 clk_sys = ~clk_sys;
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_compared++;
		if (got !== ex) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic axiWr(input logic [11:0] a, input logic [31:0] d);
		logic awP;
		logic wP;
		awP = 1'b1;
		wP = 1'b1;
		@(posedge clk_sys);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		while (awP || wP) begin
			@(posedge clk_sys);
			if (awP && awready === 1'b1) begin
				awvalid <= 1'b0;
				awP = 1'b0;
			end
			if (wP && wready === 1'b1) begin
				wvalid <= 1'b0;
				wP = 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge clk_sys); while (bvalid !== 1'b1);
		bs = bresp;
		bready <= 1'b0;
	endtask
	task automatic axiRd(input logic [11:0] a);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk_sys); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk_sys); while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task automatic rdChk(input logic [11:0] a, input logic [31:0] ex, input string nm);
		axiRd(a);
		chk(nm, ex, rd);
	endtask
	// Channel parameters, zero segments, then the command word
	task automatic run(input logic [11:0] ch, input logic [31:0] src, dst, blk,
		bst, wt, cmd);
		axiWr(12'h040 + {ch[7:0], 4'h0}, src);
		axiWr(12'h044 + {ch[7:0], 4'h0}, dst);
		axiWr(12'h048 + {ch[7:0], 4'h0}, blk);
		axiWr(12'h04C + {ch[7:0], 4'h0}, bst);
		axiWr(12'h080 + {ch[9:0], 2'h0}, 32'h00000000);
		axiWr(12'h090 + {ch[9:0], 2'h0}, 32'h00000000);
		axiWr(12'h0A0 + {ch[9:0], 2'h0}, wt);
		pairs = 0;
		gap = 0;
		minGap = 999;
		axiWr(`FCDS_A_CMD, cmd);
	endtask
	task automatic waitDone(input int blk);
		repeat (3) @(posedge clk_sys);
		while (devBusy !== 1'b0) @(posedge clk_sys);
		chk("pairs", blk, pairs);
	endtask
	task tally_and_finish;
		$display("mismatches %0d comparisons %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Counts pairs, bus-free gaps and the run time
	always @(posedge clk_sys) begin
		cyc++;
		if (lnk.memRead === 1'b1 && rdPrev !== 1'b1) pairs++;
		rdPrev = lnk.memRead;
		if (lnk.busOe === 1'b1) begin
			if (gap > 0 && gap < minGap) minGap = gap;
			gap = 0;
		end else if (lnk.dmaBusy === 1'b1 && pairs > 0) gap++;
		if (cyc == 30000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		axiWr(`FCDS_A_CTRL, 32'h00000001);
		for (i = 0; i < 64; i++) begin
			em[i] = {8'(i + 16), 8'hC3, 8'(i), 8'h5A};
			axiWr(12'h100 + 12'(i * 4), em[i]);
		end
		run(12'h001, 0, 16, 3, 8, 0, 32'h00000003);
		waitDone(3);
		for (i = 0; i < 3; i++) em[16 + i] = em[i];
		run(12'h002, 4, 24, 2, 8, 0, 32'h0000000D);
		waitDone(2);
		em[24] = em[4];
		em[25] = em[4];
		run(12'h002, 5, 26, 2, 8, 0, 32'h00000015);
		waitDone(2);
		em[26] = em[6];
		run(12'h003, 8, 30, 1, 8, 0, 32'h00000027);
		waitDone(1);
		em[30][31:24] = em[8][31:24];
		run(12'h003, 9, 31, 1, 8, 0, 32'h00000047);
		waitDone(1);
		em[31][31:16] = em[9][31:16];
		run(12'h000, 10, 40, 3, 1, 5, 32'h00000001);
		waitDone(3);
		chk("gap", 32'h00000001, {31'h0, minGap >= 6});
		for (i = 0; i < 3; i++) em[40 + i] = em[10 + i];
		run(12'h001, 12, 48, 6, 8, 0, 32'h00000003);
		// Grant withdrawn in mid-run
		while (pairs < 2) @(posedge clk_sys);
		axiWr(`FCDS_A_CTRL, 32'h00000000);
		repeat (12) @(posedge clk_sys);
		rdChk(`FCDS_A_STAT, 32'h0000060C, "status");
		chk("stall", 32'h00000001, {31'h0,
			pairs < 6 && lnk.busOe === 1'b0});
		axiWr(12'h064, 32'h00000038);
		axiWr(`FCDS_A_CMD, 32'h00000005);
		chk("bresp", 32'h00000000, {30'h0, bs});
		axiWr(`FCDS_A_CTRL, 32'h00000001);
		waitDone(6);
		for (i = 0; i < 6; i++) em[48 + i] = em[12 + i];
		run(12'h003, 0, 60, 0, 8, 0, 32'h00000007);
		waitDone(0);
		rdChk(`FCDS_A_STAT, 32'h00000801, "status");
		axiRd(12'h300);
		chk("resp", 32'h00000002, {30'h0, rs});
		chk("rdata", 32'h00000000, rd);
		axiWr(12'h300, 32'h00000001);
		chk("bresp", 32'h00000002, {30'h0, bs});
		for (i = 0; i < 64; i++)
			rdChk(12'h100 + 12'(i * 4), em[i], "mem");
		tally_and_finish();
	end
endmodule
`default_nettype wire
